// *** hw/prsp_pkg.sv ***
// constants and types shared by the parallel slave port block
package prsp_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned PRSP_DATA_W = 8;
   localparam int unsigned PRSP_ADDR_W = 6;
   localparam int unsigned PRSP_BUS_W  = 32;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [5:0] PRSP_OFF_PINS  = 6'h00;
   localparam logic [5:0] PRSP_OFF_LATCH = 6'h04;
   localparam logic [5:0] PRSP_OFF_DDIR  = 6'h08;
   localparam logic [5:0] PRSP_OFF_CDIR  = 6'h0c;
   localparam logic [5:0] PRSP_OFF_ACFG  = 6'h10;
   localparam logic [5:0] PRSP_OFF_CLAT  = 6'h14;
   localparam logic [5:0] PRSP_OFF_IFLAG = 6'h18;
   localparam logic [5:0] PRSP_OFF_IEN   = 6'h1c;
   localparam logic [5:0] PRSP_OFF_IPRI  = 6'h20;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned PRSP_CDIR_IBF  = 7;
   localparam int unsigned PRSP_CDIR_OBF  = 6;
   localparam int unsigned PRSP_CDIR_INPUT_OVERFLOW_FLAG = 5;
   localparam int unsigned PRSP_CDIR_SEL  = 4;
   localparam int unsigned PRSP_IRQ_BIT   = 7;
   localparam int unsigned PRSP_PIN_RD    = 0;
   localparam int unsigned PRSP_PIN_WR    = 1;
   localparam int unsigned PRSP_PIN_CS    = 2;

   // ------------------------------------------------------------
   // reset values and limits
   // ------------------------------------------------------------
   localparam logic [7:0] PRSP_RST_LATCH = 8'h00;
   localparam logic [7:0] PRSP_RST_DDIR  = 8'hff;
   localparam logic [2:0] PRSP_RST_CDIR  = 3'h7;
   localparam logic [2:0] PRSP_RST_CLAT  = 3'h0;
   localparam logic [3:0] PRSP_RST_ACFG  = 4'h0;
   localparam logic [3:0] PRSP_ACFG_MIN  = 4'ha;
   localparam int unsigned PRSP_SYNC_STAGES = 2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } prsp_strobe_t;

   typedef struct packed {
      logic input_full_flag;
      logic output_full_flag;
      logic input_overflow_flag;
   } prsp_flags_t;

endpackage

// *** hw/prsp_sync.sv ***
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module prsp_sync
   import prsp_pkg::*;
#(
   parameter int unsigned WIDTH = 3,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ------------------------------------------------------------
   // first stage feeds only the second
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// *** hw/prsp_top.sv ***
// parallel slave port: external 8-bit processor access to the data port latch
//
// What this block does
// - setting the slave port select bit enables slave operation unless the multi-output PWM mode is running.
// - the external processor reads and writes the data port latch as one 8-bit latch over an 8-bit bus.
// - in slave mode control pin 0 is the read strobe, pin 1 the write strobe and pin 2 the chip select, all low.
// - the strobes only work with all three control directions set to input and the analog field in 1010..1111.
// - a write cycle starts when chip select and write strobe are first seen low and ends when either is high.
// - the end of an external write sets the port read/write interrupt flag and the input full flag.
// - when chip select and read strobe are first seen low the latch drives the pins and output full clears.
// - a firmware write during an active read shows on the pins at once but leaves output full clear.
// - when chip select or read strobe goes high after a read the pins float again and the interrupt flag sets.
// - firmware should wait for the interrupt flag and then poll input full and output full to act.
// - the external processor may access the port at any time without reference to the device clock.
// - the interrupt flag, enable and priority bits exist only on the larger variant and read zero otherwise.
// - an external write while the previous input word is unread sets input overflow, cleared only by software.
// - output full reads one while a firmware word is unread by the external side and zero once read.
// - the port read/write interrupt flag stays set after a cycle until software clears it.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module prsp_top
   import prsp_pkg::*;
#(
   parameter logic HAS_PORT = 1'b1
) (
   input  wire logic                   REF_CLK,
   input  wire logic                   ARST_N,
   input  wire logic [PRSP_ADDR_W-1:0] AVS_ADDRESS,
   input  wire logic                   AVS_READ,
   input  wire logic                   AVS_WRITE,
   input  wire logic [PRSP_BUS_W-1:0]  AVS_WRITEDATA,
   input  wire logic [3:0]             AVS_BYTEENABLE,
   output logic      [PRSP_BUS_W-1:0]  AVS_READDATA,
   output logic                        AVS_WAITREQUEST,
   input  wire logic [PRSP_DATA_W-1:0] DATA_IN,
   output logic      [PRSP_DATA_W-1:0] DATA_OUT,
   output logic      [PRSP_DATA_W-1:0] DATA_OE,
   input  wire logic [2:0]             CTRL_IN,
   output logic      [2:0]             CTRL_OUT,
   output logic      [2:0]             CTRL_OE,
   input  wire logic                   PWM_MULTI_ACTIVE,
   output logic                        IRQ,
   output logic                        IRQ_HIGH_PRIO
);

   // ------------------------------------------------------------
   // address decode helper
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [PRSP_ADDR_W-1:0] addr,
                                     input logic [5:0] off);
      addr_hit = (addr == off);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [PRSP_DATA_W-1:0] latch_q;
   logic [PRSP_DATA_W-1:0] ddir_q;
   logic [PRSP_DATA_W-1:0] in_word_q;
   logic [PRSP_DATA_W-1:0] shadow_q;
   logic [PRSP_DATA_W-1:0] pins_q;
   logic [2:0]             cdir_q;
   logic [2:0]             clat_q;
   logic                   sel_q;
   logic [3:0]             acfg_q;
   prsp_flags_t            flags_q;
   prsp_flags_t            flags_d;
   logic                   iflag_q;
   logic                   iflag_d;
   logic                   ien_q;
   logic                   ipri_q;
   logic                   rd_act_q;
   logic                   wr_act_q;
   logic                   ack_q;
   logic [PRSP_BUS_W-1:0]  rdata_q;
   logic [PRSP_BUS_W-1:0]  rdata_d;

   // ------------------------------------------------------------
   // strobe synchronisation
   // ------------------------------------------------------------
   logic [2:0]   ctrl_sync;
   prsp_strobe_t strb;

   prsp_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h7)
   ) u_sync (
      .clk      (REF_CLK),
      .arst_n   (ARST_N),
      .async_in (CTRL_IN),
      .sync_out (ctrl_sync)
   );

   assign strb.rd_n = ctrl_sync[PRSP_PIN_RD];
   assign strb.wr_n = ctrl_sync[PRSP_PIN_WR];
   assign strb.cs_n = ctrl_sync[PRSP_PIN_CS];

   // ------------------------------------------------------------
   // mode and cycle detection
   // ------------------------------------------------------------
   wire ctrl_all_in;
   wire acfg_digital;
   wire slave_on;
   wire rd_now;
   wire wr_now;
   wire rd_start;
   wire rd_end;
   wire wr_end;

   // directions input and analog field digital
   assign ctrl_all_in  = (cdir_q == 3'h7);
   assign acfg_digital = (acfg_q >= PRSP_ACFG_MIN);
   assign slave_on = HAS_PORT & sel_q & ~PWM_MULTI_ACTIVE & ctrl_all_in & acfg_digital;

   // cycles follow the strobes, not software timing
   assign rd_now = slave_on & ~strb.cs_n & ~strb.rd_n;
   assign wr_now = slave_on & ~strb.cs_n & ~strb.wr_n;
   // read begins on first low of both
   assign rd_start = rd_now & ~rd_act_q;
   assign rd_end = ~rd_now & rd_act_q;
   // write spans both low, ends on either high
   assign wr_end = ~wr_now & wr_act_q;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end else begin
         rd_act_q <= rd_now;
         wr_act_q <= wr_now;
      end
   end

   // capture the bus byte while the write is active
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         shadow_q  <= PRSP_RST_LATCH;
         in_word_q <= PRSP_RST_LATCH;
         pins_q    <= PRSP_RST_LATCH;
      end else begin
         pins_q <= DATA_IN;
         if (wr_now) begin
            shadow_q <= DATA_IN;
         end
         if (wr_end) begin
            in_word_q <= shadow_q;
         end
      end
   end

   // ------------------------------------------------------------
   // avalon slave: one wait cycle per access
   // ------------------------------------------------------------
   wire req;
   wire acc_wr;
   wire acc_rd;
   wire lane0;
   wire [7:0] wdat;
   wire hit_pins;
   wire hit_latch;
   wire hit_ddir;
   wire hit_cdir;
   wire hit_acfg;
   wire hit_clat;
   wire hit_iflag;
   wire hit_ien;
   wire hit_ipri;
   wire fw_latch_wr;
   wire fw_pins_rd;

   assign req             = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_q;
   assign lane0           = AVS_BYTEENABLE[0];
   assign acc_wr          = AVS_WRITE & ack_q & lane0;
   assign acc_rd          = AVS_READ & ack_q;
   assign wdat            = AVS_WRITEDATA[7:0];

   assign hit_pins  = addr_hit(AVS_ADDRESS, PRSP_OFF_PINS);
   assign hit_latch = addr_hit(AVS_ADDRESS, PRSP_OFF_LATCH);
   assign hit_ddir  = addr_hit(AVS_ADDRESS, PRSP_OFF_DDIR);
   assign hit_cdir  = addr_hit(AVS_ADDRESS, PRSP_OFF_CDIR);
   assign hit_acfg  = addr_hit(AVS_ADDRESS, PRSP_OFF_ACFG);
   assign hit_clat  = addr_hit(AVS_ADDRESS, PRSP_OFF_CLAT);
   assign hit_iflag = addr_hit(AVS_ADDRESS, PRSP_OFF_IFLAG);
   assign hit_ien   = addr_hit(AVS_ADDRESS, PRSP_OFF_IEN);
   assign hit_ipri  = addr_hit(AVS_ADDRESS, PRSP_OFF_IPRI);

   assign fw_latch_wr = acc_wr & (hit_pins | hit_latch);
   assign fw_pins_rd  = acc_rd & hit_pins & slave_on;

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_q <= PRSP_RST_LATCH;
         ddir_q  <= PRSP_RST_DDIR;
         cdir_q  <= PRSP_RST_CDIR;
         clat_q  <= PRSP_RST_CLAT;
         sel_q   <= 1'b0;
         acfg_q  <= PRSP_RST_ACFG;
         ien_q   <= 1'b0;
         ipri_q  <= 1'b0;
      end else begin
         // new latch value reaches the pins at once
         if (fw_latch_wr) begin
            latch_q <= wdat;
         end
         if (acc_wr & hit_ddir) begin
            ddir_q <= wdat;
         end
         if (acc_wr & hit_cdir) begin
            cdir_q <= wdat[2:0];
            sel_q  <= wdat[PRSP_CDIR_SEL];
         end
         if (acc_wr & hit_clat) begin
            clat_q <= wdat[2:0];
         end
         if (acc_wr & hit_acfg) begin
            acfg_q <= wdat[3:0];
         end
         // enable and priority absent on small variant
         if (acc_wr & hit_ien) begin
            ien_q <= HAS_PORT & wdat[PRSP_IRQ_BIT];
         end
         if (acc_wr & hit_ipri) begin
            ipri_q <= HAS_PORT & wdat[PRSP_IRQ_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // status flags: hardware set wins over software clear
   // ------------------------------------------------------------
   wire input_overflow_flag_clr;
   wire iflag_clr;
   wire iflag_set;

   assign input_overflow_flag_clr  = acc_wr & hit_cdir & ~wdat[PRSP_CDIR_INPUT_OVERFLOW_FLAG];
   assign iflag_clr = acc_wr & hit_iflag & wdat[PRSP_IRQ_BIT];
   // write end raises the interrupt flag
   // read end raises the interrupt flag
   assign iflag_set = HAS_PORT & (wr_end | rd_end);

   always_comb begin
      flags_d = flags_q;
      if (wr_end) begin
         flags_d.input_full_flag = 1'b1;
      end else if (fw_pins_rd) begin
         flags_d.input_full_flag = 1'b0;
      end
      // overflow when unread word is overwritten
      if (wr_end & flags_q.input_full_flag) begin
         flags_d.input_overflow_flag = 1'b1;
      end else if (input_overflow_flag_clr) begin
         flags_d.input_overflow_flag = 1'b0;
      end
      // output full until the external side reads
      // write during a read keeps it clear
      if (rd_start) begin
         flags_d.output_full_flag = 1'b0;
      end else if (fw_latch_wr & ~rd_act_q) begin
         flags_d.output_full_flag = 1'b1;
      end
      iflag_d = iflag_q;
      if (iflag_set) begin
         iflag_d = 1'b1;
      end else if (iflag_clr) begin
         iflag_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         flags_q <= '0;
         iflag_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         iflag_q <= iflag_d;
      end
   end

   // ------------------------------------------------------------
   // read data mux, registered one cycle before the answer
   // ------------------------------------------------------------
   wire [7:0] pins_view;
   wire [7:0] cdir_view;

   assign pins_view = slave_on ? in_word_q : pins_q;
   // flags polled together with the select bit
   assign cdir_view = {flags_q.input_full_flag, flags_q.output_full_flag, flags_q.input_overflow_flag, sel_q, 1'b0, cdir_q};

   always_comb begin
      rdata_d = '0;
      if (hit_pins) begin
         rdata_d[7:0] = pins_view;
      end else if (hit_latch) begin
         rdata_d[7:0] = latch_q;
      end else if (hit_ddir) begin
         rdata_d[7:0] = ddir_q;
      end else if (hit_cdir) begin
         rdata_d[7:0] = cdir_view;
      end else if (hit_acfg) begin
         rdata_d[3:0] = acfg_q;
      end else if (hit_clat) begin
         rdata_d[2:0] = clat_q;
      end else if (hit_iflag) begin
         rdata_d[PRSP_IRQ_BIT] = HAS_PORT & iflag_q;
      end else if (hit_ien) begin
         rdata_d[PRSP_IRQ_BIT] = ien_q;
      end else if (hit_ipri) begin
         rdata_d[PRSP_IRQ_BIT] = ipri_q;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= '0;
      end else if (AVS_READ & ~ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   assign AVS_READDATA = rdata_q;

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   assign DATA_OUT = latch_q;
   assign DATA_OE  = slave_on ? {PRSP_DATA_W{rd_act_q}} : ~ddir_q;
   assign CTRL_OUT = clat_q;
   assign CTRL_OE  = ~cdir_q;

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   assign IRQ           = iflag_q & ien_q;
   assign IRQ_HIGH_PRIO = iflag_q & ien_q & ipri_q;

endmodule

// *** tb/prsp_host_model.sv ***
// external 8-bit processor model driving the slave port strobes
`timescale 1ns/100ps
module prsp_host_model
   import prsp_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   [7:0] pin_d,
   output prsp_strobe_t strobe,
   output logic        [7:0] drv_d
);
   initial begin
      strobe = 3'b111;
      drv_d = 8'h00;
   end
   // --------------------
   // bus cycles
   // --------------------
   // write cycle
   task automatic wr_cycle(input logic [7:0] d);
      drv_d <= d;
      strobe <= 3'b001;
      repeat (5) @(posedge clk);
      strobe <= 3'b111;
      repeat (5) @(posedge clk);
      // released bus shows the inverse
      drv_d <= ~d;
      @(posedge clk);
   endtask
   task automatic rd_cycle(input int low, output logic [7:0] q);
      strobe <= 3'b010;
      repeat (low) @(posedge clk);
      q = pin_d;
      strobe <= 3'b111;
      repeat (6) @(posedge clk);
   endtask
endmodule

// *** tb/prsp_top_sva.sv ***
// concurrent checks on the slave port top pins
`timescale 1ns/100ps
module prsp_top_sva
   import prsp_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        ARST_N,
   input wire logic [5:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic [7:0]  DATA_OUT,
   input wire logic [7:0]  DATA_OE,
   input wire logic [2:0]  CTRL_IN,
   input wire logic [2:0]  CTRL_OE,
   input wire logic        IRQ,
   input wire logic        IRQ_HIGH_PRIO
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // --------------------
   // bus handshake steps
   // --------------------
   sequence s_req_held;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_rd_done;
      AVS_READ && !AVS_WAITREQUEST;
   endsequence
   sequence s_wr_done(logic [5:0] a);
      AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == a;
   endsequence
   a_wait_one_cycle: assert property (s_req_held |=> !AVS_WAITREQUEST)
      else $error("wait lasted beyond one cycle");
   a_wait_when_idle: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
      else $error("wait raised without a request");
   a_read_upper_zero: assert property (s_rd_done |-> AVS_READDATA[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_unmapped_reads_zero: assert property (s_rd_done ##0 AVS_ADDRESS > PRSP_OFF_IPRI |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   a_latch_to_pins: assert property (s_wr_done(PRSP_OFF_LATCH) |=> DATA_OUT == $past(AVS_WRITEDATA[7:0]))
      else $error("latch write not on data pins");
   a_ctrl_dir_oe: assert property (s_wr_done(PRSP_OFF_CDIR) |=> CTRL_OE == ~$past(AVS_WRITEDATA[2:0]))
      else $error("control enables do not follow directions");
   a_read_end_float: assert property ($rose(CTRL_IN[PRSP_PIN_RD]) && DATA_OE == 8'hff |-> ##[1:4] DATA_OE == 8'h00)
      else $error("data pins still driven after read end");
   a_irq_flag_sticky: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
      else $error("interrupt dropped without a register write");
   a_prio_within_irq: assert property (IRQ_HIGH_PRIO |-> IRQ)
      else $error("high priority request without interrupt");
endmodule
bind prsp_top prsp_top_sva u_sva (
   .REF_CLK(REF_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DATA_OUT(DATA_OUT),
   .DATA_OE(DATA_OE), .CTRL_IN(CTRL_IN), .CTRL_OE(CTRL_OE), .IRQ(IRQ), .IRQ_HIGH_PRIO(IRQ_HIGH_PRIO)
);

// *** tb/prsp_top_tb.sv ***
// self-checking bench for the parallel slave port
`timescale 1ns/100ps
module prsp_top_tb
   import prsp_pkg::*;
;
   typedef struct packed {
      logic [5:0] a;
      logic [7:0] rst;
      logic [7:0] wd;
      logic [7:0] exp;
   } prsp_row_t;
   localparam prsp_row_t rows [8] = '{
      '{PRSP_OFF_CDIR, 8'h07, 8'h15, 8'h15}, '{PRSP_OFF_DDIR, 8'hff, 8'h5a, 8'h5a},
      '{PRSP_OFF_LATCH, 8'h00, 8'h3c, 8'h3c}, '{PRSP_OFF_CLAT, 8'h00, 8'hff, 8'h07},
      '{PRSP_OFF_ACFG, 8'h00, 8'hfb, 8'h0b}, '{PRSP_OFF_IEN, 8'h00, 8'hff, 8'h80},
      '{PRSP_OFF_IPRI, 8'h00, 8'hff, 8'h80}, '{6'h24, 8'h00, 8'hff, 8'h00}};
   logic         REF_CLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic         PWM_MULTI_ACTIVE, IRQ, IRQ_HIGH_PRIO;
   logic [3:0]   AVS_BYTEENABLE;
   logic [5:0]   AVS_ADDRESS;
   logic [31:0]  AVS_WRITEDATA, AVS_READDATA;
   logic [7:0]   DATA_IN, DATA_OUT, DATA_OE, drv_d, rd_q, ext_q;
   logic [2:0]   CTRL_IN, CTRL_OUT, CTRL_OE;
   prsp_strobe_t strobe;
   int           miscompares = 0;
   int           comparisons = 0;
   // wire levels from all drivers
   assign DATA_IN = (DATA_OE & DATA_OUT) | (~DATA_OE & drv_d);
   assign CTRL_IN = (CTRL_OE & CTRL_OUT) | (~CTRL_OE & strobe);
   prsp_top u_dut (
      .REF_CLK(REF_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DATA_IN(DATA_IN),
      .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .CTRL_IN(CTRL_IN), .CTRL_OUT(CTRL_OUT),
      .CTRL_OE(CTRL_OE), .PWM_MULTI_ACTIVE(PWM_MULTI_ACTIVE), .IRQ(IRQ), .IRQ_HIGH_PRIO(IRQ_HIGH_PRIO));
   prsp_host_model u_host (.clk(REF_CLK), .pin_d(DATA_IN), .strobe(strobe), .drv_d(drv_d));
   // small variant: port absent, flag and enable bits read zero
   logic [31:0]  sm_rdata;
   logic         sm_irq;
   prsp_top #(.HAS_PORT(1'b0)) u_dut_small (
      .REF_CLK(REF_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(sm_rdata), .AVS_WAITREQUEST(), .DATA_IN(DATA_IN),
      .DATA_OUT(), .DATA_OE(), .CTRL_IN(CTRL_IN), .CTRL_OUT(),
      .CTRL_OE(), .PWM_MULTI_ACTIVE(PWM_MULTI_ACTIVE), .IRQ(sm_irq), .IRQ_HIGH_PRIO());
   // --------------------
   // tasks
   // --------------------
   task automatic wait_ack();
      do begin
         @(posedge REF_CLK);
      end while (AVS_WAITREQUEST !== 1'b0);
   endtask
   task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_WRITE <= 1'b1;
      wait_ack();
      AVS_WRITE <= 1'b0;
      @(posedge REF_CLK);
   endtask
   task automatic bus_rd(input logic [5:0] a, output logic [7:0] q);
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      wait_ack();
      q = AVS_READDATA[7:0];
      AVS_READ <= 1'b0;
      @(posedge REF_CLK);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      REF_CLK = 1'b0;
      forever #4 REF_CLK = ~REF_CLK;
   end
   initial begin
      repeat (5000) @(posedge REF_CLK);
      miscompares++;
      close_out();
   end
   // --------------------
   // main sequence
   // --------------------
   initial begin
      ARST_N = 1'b0;
      AVS_ADDRESS = 6'h00;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0;
      AVS_BYTEENABLE = 4'h1;
      PWM_MULTI_ACTIVE = 1'b0;
      repeat (16) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      @(posedge REF_CLK);
      chk_byte(DATA_OE, 8'h00);
      chk_bit(IRQ, 1'b0);
      foreach (rows[i]) begin
         bus_rd(rows[i].a, rd_q);
         chk_byte(rd_q, rows[i].rst);
         bus_wr(rows[i].a, rows[i].wd);
         bus_rd(rows[i].a, rd_q);
         chk_byte(rd_q, rows[i].exp);
      end
      chk_byte({5'h00, CTRL_OUT}, 8'h07);
      chk_byte(DATA_OE, 8'ha5);
      bus_wr(PRSP_OFF_DDIR, 8'hff);
      // slave mode refused: analog field too low, then multi-output pwm
      bus_wr(PRSP_OFF_CDIR, 8'h17);
      bus_wr(PRSP_OFF_ACFG, 8'h09);
      u_host.wr_cycle(8'h11);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_bit(rd_q[PRSP_CDIR_IBF], 1'b0);
      bus_wr(PRSP_OFF_ACFG, 8'h0a);
      PWM_MULTI_ACTIVE <= 1'b1;
      u_host.wr_cycle(8'h22);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_bit(rd_q[PRSP_CDIR_IBF], 1'b0);
      // external writes, second one overflowing
      PWM_MULTI_ACTIVE <= 1'b0;
      u_host.wr_cycle(8'ha5);
      chk_bit(IRQ_HIGH_PRIO, 1'b1);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'hd7);
      u_host.wr_cycle(8'hc3);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'hf7);
      bus_rd(PRSP_OFF_PINS, rd_q);
      chk_byte(rd_q, 8'hc3);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'h77);
      bus_wr(PRSP_OFF_CDIR, 8'h17);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'h57);
      chk_bit(IRQ, 1'b1);
      bus_wr(PRSP_OFF_IFLAG, 8'h80);
      chk_bit(IRQ, 1'b0);
      // external read with a firmware write in mid-read
      bus_wr(PRSP_OFF_LATCH, 8'h96);
      fork
         u_host.rd_cycle(12, ext_q);
         begin
            repeat (6) @(posedge REF_CLK);
            chk_byte(DATA_OE, 8'hff);
            bus_wr(PRSP_OFF_LATCH, 8'h69);
         end
      join
      chk_byte(ext_q, 8'h69);
      chk_byte(DATA_OE, 8'h00);
      chk_bit(IRQ, 1'b1);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'h17);
      bus_wr(PRSP_OFF_IEN, 8'h00);
      chk_bit(IRQ, 1'b0);
      bus_wr(PRSP_OFF_IEN, 8'h80);
      chk_bit(IRQ, 1'b1);
      bus_rd(PRSP_OFF_IEN, rd_q);
      chk_byte(rd_q, 8'h80);
      chk_byte(sm_rdata[7:0], 8'h00);
      chk_bit(sm_irq, 1'b0);
      bus_rd(PRSP_OFF_IFLAG, rd_q);
      chk_byte(rd_q, 8'h80);
      bus_wr(PRSP_OFF_IFLAG, 8'h80);
      chk_bit(IRQ, 1'b0);
      bus_wr(PRSP_OFF_LATCH, 8'h5a);
      bus_rd(PRSP_OFF_CDIR, rd_q);
      chk_byte(rd_q, 8'h57);
      // write without the low byte lane is ignored
      AVS_BYTEENABLE <= 4'he;
      bus_wr(PRSP_OFF_LATCH, 8'h11);
      AVS_BYTEENABLE <= 4'h1;
      bus_rd(PRSP_OFF_LATCH, rd_q);
      chk_byte(rd_q, 8'h5a);
      close_out();
   end
endmodule
